//--- logic/tom_pkg.sv
// Shared constants, carrier types and helper functions for the
// transmit OTN client monitor.
// Assumes a single 10 MHz core clock and 64b/66b lane blocks.
package tom_pkg;

  localparam int LANES = 5;
  localparam int CLK_PERIOD_NS = 100;

  // Sync header encodings, [65] is sent first
  localparam logic [1:0] SH_DATA = 2'h1;
  localparam logic [1:0] SH_CTRL = 2'h2;

  localparam logic [7:0] TYPE_START = 8'h78;
  localparam logic [7:0] TYPE_OSET = 8'h4B;
  localparam logic [7:0] PRE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hD5;
  localparam logic [7:0] RF_CODE = 8'h02;
  localparam logic [3:0] NOT_TERM = 4'hF;

  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

  localparam logic [15:0] STD_MIN_LEN = 16'h0040;
  localparam logic [15:0] FCS_LEN = 16'h0004;
  localparam logic [15:0] LEN_SAT = 16'hFFFF;

  // Self-synchronising x^58 + x^39 + 1 descrambler taps
  localparam int SCR_TAP_A = 38;
  localparam int SCR_TAP_B = 57;
  localparam logic [57:0] SCR_RESET = 58'h0;

  typedef struct packed {
    logic [1:0] hdr;
    logic [63:0] pay;
  } tom_block_t;

  typedef tom_block_t [LANES-1:0] tom_lanes_t;

  typedef struct packed {
    logic long_bad_crc_count;
    logic long_good_crc_count;
    logic long_any_crc_count;
    logic [1:0] short_good_crc_count;
    logic [1:0] short_bad_crc_count;
    logic normal_bad_crc_count;
    logic [2:0] inverted_crc_count;
    logic bad_preamble;
    logic bad_start_delimiter;
  } tom_stats_t;

  typedef struct packed {
    logic [57:0] state;
    logic [63:0] data;
  } tom_descr_t;

  // Descramble one payload, bit 63 first on the line
  function automatic tom_descr_t descramble(logic [57:0] st,
                                            logic [63:0] d);
    tom_descr_t r;
    r.state = st;
    r.data = 64'h0;
    for (int i = 63; i >= 0; i--) begin
      r.data[i] = d[i] ^ r.state[SCR_TAP_A] ^ r.state[SCR_TAP_B];
      r.state = {r.state[56:0], d[i]};
    end
    return r;
  endfunction

  // Ethernet byte idx of a payload; line order is LSB first
  function automatic logic [7:0] get_byte(logic [63:0] p, int idx);
    logic [7:0] r;
    r = 8'h0;
    for (int j = 0; j < 8; j++) begin
      r[j] = p[63 - 8 * idx - j];
    end
    return r;
  endfunction

  // Reflected CRC-32 over one byte
  function automatic logic [31:0] crc_byte(logic [31:0] c,
                                           logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int j = 0; j < 8; j++) begin
      r = (r[0] ^ b[j]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Data bytes carried by a terminate block, NOT_TERM otherwise
  function automatic logic [3:0] term_len(logic [7:0] ty);
    logic [3:0] r;
    unique case (ty)
      8'h87: r = 4'h0;
      8'h99: r = 4'h1;
      8'hAA: r = 4'h2;
      8'hB4: r = 4'h3;
      8'hCC: r = 4'h4;
      8'hD2: r = 4'h5;
      8'hE1: r = 4'h6;
      8'hFF: r = 4'h7;
      default: r = NOT_TERM;
    endcase
    return r;
  endfunction

endpackage

//--- logic/tom_descrambler.sv
// Lane descrambler: one pipeline stage that descrambles the five lane
// payloads in lane order with one shared scrambler state.
// Assumes lane blocks from logic on the same clock.
`timescale 1ns/1ps
module tom_descrambler
  import tom_pkg::*;
(
  input wire logic clk_in,             // core clock
  input wire logic srst_in,            // synchronous reset
  input wire tom_lanes_t lanes_in,     // scrambled lane blocks
  input wire logic valid_in,           // lane blocks valid
  input wire logic am_flag_in,         // alignment markers present
  input wire logic stats_config_in,    // statistics gathering on
  output tom_lanes_t lanes_out,        // descrambled lane blocks
  output logic valid_out,              // descrambled blocks valid
  output logic am_out                  // blocks are markers, skip
);

  logic [57:0] scr_state;
  logic [57:0] next_scr_state;
  tom_lanes_t next_lanes;
  logic skip;

  // Flag only honoured with statistics gathering; else markers
  // pass as ordinary blocks, unidentified
  assign skip = am_flag_in & stats_config_in;

  always_comb begin
    tom_descr_t d;
    d = '{state: scr_state, data: 64'h0};
    next_scr_state = scr_state;
    next_lanes = lanes_in;
    for (int l = 0; l < LANES; l++) begin
      // Header bypasses the scrambler, only payload is touched
      d = descramble(next_scr_state, lanes_in[l].pay);
      next_lanes[l].pay = d.data;
      next_scr_state = d.state;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      scr_state <= SCR_RESET;
    end else if (valid_in && !skip) begin
      scr_state <= next_scr_state;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      lanes_out <= '0;
      valid_out <= 1'b0;
      am_out <= 1'b0;
    end else begin
      lanes_out <= skip ? lanes_in : next_lanes;
      valid_out <= valid_in;
      am_out <= valid_in & skip;
    end
  end

endmodule

//--- logic/tom_monitor.sv
// Transmit OTN input port with egress client monitor: forwards lane
// blocks to the gearbox and decodes them into per-cycle statistics.
// Assumes all inputs come from logic on the 10 MHz core clock.
`timescale 1ns/1ps

// Overview of operation
// - One core clock, one transmit reset
// - Marker flag decoded only when gathering statistics, forwarded to egress gated by valid
// - Blocks decoded only while valid is high, registered to egress every cycle
// - Lanes are 66 bits, header on top
// - Longer than max length means oversized
// - Shorter than min length means undersized
// - Start delimiter checked when enabled
// - Preamble checked when enabled
// - Bad-FCS binning chosen when not inserting
// - Bad FCS of a normal-length frame still flagged, frame unchanged
// - FEC path selected only while enabled
// - Oversized with bad FCS counted
// - Oversized with good FCS counted
// - Every oversized frame counted
// - Undersized good FCS frames counted
// - Undersized bad FCS frames counted
// - Normal-length bad FCS frames counted
// - Inverted FCS frames counted, back to back
// - Remote fault shown as a level
// - Header 01 data, 10 control
module tom_monitor
  import tom_pkg::*;
(
  input wire logic clk_in,                      // core clock
  input wire logic srst_in,                     // synchronous reset
  input wire tom_lanes_t lane_block_in,         // five 66b blocks
  input wire logic lane_data_valid_in,          // blocks valid
  input wire logic lane0_marker_in,             // lane 0 on bus 0
  input wire logic alignment_marker_flag_in,    // marker words
  input wire logic bubble_request_in,           // bubble next cycle
  input wire logic stats_config_in,             // gather statistics
  input wire logic [14:0] max_frame_length_in,  // oversize limit
  input wire logic [7:0] min_frame_length_in,   // undersize limit
  input wire logic check_start_delimiter_in,    // check SFD
  input wire logic check_preamble_en_in,        // check preamble
  input wire logic crc_insert_en_in,            // FCS inserted
  input wire logic accept_bad_crc_as_good_in,   // bin bad as good
  input wire logic fec_path_en_in,              // route via RS-FEC
  output tom_lanes_t egress_block_out,          // blocks to gearbox
  output logic egress_valid_out,                // egress valid
  output logic egress_lane0_out,                // egress lane 0 mark
  output logic egress_am_out,                   // egress marker flag
  output logic egress_bubble_out,               // bubble to gearbox
  output logic fec_route_out,                   // FEC path selected
  output tom_stats_t stats_out,                 // increments
  output logic far_fault_flag_out               // remote fault level
);

  typedef struct packed {
    logic active;
    logic [15:0] len;
    logic [31:0] crc;
    logic [127:0] hist;
    logic [31:0] tail;
  } tom_frame_t;

  tom_lanes_t mon_lanes;
  logic mon_valid;
  logic mon_am;
  tom_frame_t frame;
  tom_frame_t next_frame;
  tom_stats_t next_stats;
  logic next_far_fault;

  // Running CRC kept four bytes behind so the FCS can be compared
  // against both the correct value and its inverse
  function automatic tom_frame_t take_byte(tom_frame_t f,
                                           logic [7:0] b);
    tom_frame_t r;
    r = f;
    r.hist = {f.hist[95:0], f.crc};
    r.crc = crc_byte(f.crc, b);
    r.tail = {f.tail[23:0], b};
    if (f.len != LEN_SAT) begin
      r.len = f.len + 16'h0001;
    end
    return r;
  endfunction

  function automatic logic [2:0] clamp3(int v, int lim);
    return (v > lim) ? 3'(lim) : 3'(v);
  endfunction

  tom_descrambler u_descr (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .lanes_in(lane_block_in),
    .valid_in(lane_data_valid_in),
    .am_flag_in(alignment_marker_flag_in),
    .stats_config_in(stats_config_in),
    .lanes_out(mon_lanes),
    .valid_out(mon_valid),
    .am_out(mon_am)
  );

  // Egress is a plain register stage; data is never altered
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      egress_block_out <= '0;
      egress_valid_out <= 1'b0;
      egress_lane0_out <= 1'b0;
      egress_am_out <= 1'b0;
      egress_bubble_out <= 1'b0;
    end else begin
      egress_block_out <= lane_block_in;
      egress_valid_out <= lane_data_valid_in;
      egress_lane0_out <= lane_data_valid_in & lane0_marker_in;
      egress_am_out <= lane_data_valid_in & alignment_marker_flag_in;
      egress_bubble_out <= bubble_request_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      fec_route_out <= 1'b0;
    end else begin
      fec_route_out <= fec_path_en_in;
    end
  end

  always_comb begin
    tom_frame_t f;
    logic [7:0] ty;
    logic [3:0] tl;
    logic [31:0] recv;
    logic [31:0] expect_fcs;
    logic fcs_good;
    logic fcs_inv;
    logic ok_eff;
    logic is_long;
    logic is_short;
    logic pre_ok;
    logic rf;
    int n_lb;
    int n_lg;
    int n_la;
    int n_sg;
    int n_sb;
    int n_nb;
    int n_inv;
    int n_pre;
    int n_sfd;
    f = frame;
    ty = 8'h0;
    tl = NOT_TERM;
    recv = 32'h0;
    expect_fcs = 32'h0;
    fcs_good = 1'b0;
    fcs_inv = 1'b0;
    ok_eff = 1'b0;
    is_long = 1'b0;
    is_short = 1'b0;
    pre_ok = 1'b0;
    rf = far_fault_flag_out;
    n_lb = 0;
    n_lg = 0;
    n_la = 0;
    n_sg = 0;
    n_sb = 0;
    n_nb = 0;
    n_inv = 0;
    n_pre = 0;
    n_sfd = 0;
    for (int l = 0; l < LANES; l++) begin
      if (mon_valid && !mon_am) begin
        if (mon_lanes[l].hdr == SH_DATA) begin
          if (f.active) begin
            for (int b = 0; b < 8; b++) begin
              f = take_byte(f, get_byte(mon_lanes[l].pay, b));
            end
          end
        end else if (mon_lanes[l].hdr == SH_CTRL) begin
          ty = get_byte(mon_lanes[l].pay, 0);
          tl = term_len(ty);
          rf = 1'b0;
          if (ty == TYPE_START) begin
            pre_ok = 1'b1;
            for (int b = 1; b < 7; b++) begin
              if (get_byte(mon_lanes[l].pay, b) != PRE_BYTE) begin
                pre_ok = 1'b0;
              end
            end
            if (check_preamble_en_in && !pre_ok) begin
              n_pre++;
            end
            if (check_start_delimiter_in &&
                get_byte(mon_lanes[l].pay, 7) != SFD_BYTE) begin
              n_sfd++;
            end
            f = '{active: 1'b1, len: 16'h0, crc: CRC_INIT,
                  hist: 128'h0, tail: 32'h0};
          end else if (tl != NOT_TERM && f.active) begin
            for (int b = 1; b < 8; b++) begin
              if (4'(b) <= tl) begin
                f = take_byte(f, get_byte(mon_lanes[l].pay, b));
              end
            end
            recv = {f.tail[7:0], f.tail[15:8], f.tail[23:16],
                    f.tail[31:24]};
            expect_fcs = ~f.hist[127:96];
            fcs_good = (f.len >= FCS_LEN) && (recv == expect_fcs);
            fcs_inv = (f.len >= FCS_LEN) && (recv == ~expect_fcs);
            // Binning override applies only when FCS is not inserted
            ok_eff = fcs_good | (!crc_insert_en_in &
                                 accept_bad_crc_as_good_in);
            is_long = f.len > {1'b0, max_frame_length_in};
            is_short = f.len < {8'h0, min_frame_length_in};
            if (is_long) begin
              n_la++;
              if (ok_eff) begin
                n_lg++;
              end else begin
                n_lb++;
              end
            end
            if (is_short) begin
              if (ok_eff) begin
                n_sg++;
              end else begin
                n_sb++;
              end
            end
            // Raw FCS result so an accepted bad frame is still flagged
            if (!fcs_good && f.len >= STD_MIN_LEN && !is_long) begin
              n_nb++;
            end
            if (fcs_inv) begin
              n_inv++;
            end
            f.active = 1'b0;
          end else begin
            // Idle or ordered set ends any open frame
            f.active = 1'b0;
            rf = (ty == TYPE_OSET) &&
                 get_byte(mon_lanes[l].pay, 1) == 8'h00 &&
                 get_byte(mon_lanes[l].pay, 2) == 8'h00 &&
                 get_byte(mon_lanes[l].pay, 3) == RF_CODE;
          end
        end
      end
    end
    next_frame = f;
    next_far_fault = rf;
    next_stats.long_bad_crc_count = (n_lb != 0);
    next_stats.long_good_crc_count = (n_lg != 0);
    next_stats.long_any_crc_count = (n_la != 0);
    next_stats.short_good_crc_count = 2'(clamp3(n_sg, 3));
    next_stats.short_bad_crc_count = 2'(clamp3(n_sb, 3));
    next_stats.normal_bad_crc_count = (n_nb != 0);
    next_stats.inverted_crc_count = clamp3(n_inv, 7);
    next_stats.bad_preamble = (n_pre != 0);
    next_stats.bad_start_delimiter = (n_sfd != 0);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      frame <= '0;
    end else begin
      frame <= next_frame;
    end
  end

  // Fresh value every cycle so each increment lasts one cycle only
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      stats_out <= '0;
    end else begin
      stats_out <= next_stats;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      far_fault_flag_out <= 1'b0;
    end else begin
      far_fault_flag_out <= next_far_fault;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence blk_taken_s;
    lane_data_valid_in &&
      !(alignment_marker_flag_in && stats_config_in);
  endsequence

  sequence blk_decoded_s;
    mon_valid && !mon_am;
  endsequence

  pipe_entry_a:
    assert property (blk_taken_s |=> blk_decoded_s)
      else $error("valid lane blocks not passed to the decoder");

  marker_ignore_a:
    assert property (!$past(stats_config_in) |-> !mon_am)
      else $error("marker flag used without statistics gathering");

  idle_quiet_a:
    assert property (!$past(lane_data_valid_in, 2) |->
                     stats_out == '0)
      else $error("increment raised with no valid input");

  long_split_a:
    assert property (stats_out.long_any_crc_count ==
                     (stats_out.long_good_crc_count |
                      stats_out.long_bad_crc_count))
      else $error("oversize total disagrees with its split");

  accept_good_a:
    assert property ($past(!crc_insert_en_in &&
                           accept_bad_crc_as_good_in) |->
                     !stats_out.long_bad_crc_count &&
                     stats_out.short_bad_crc_count == 2'h0)
      else $error("bad FCS binned as bad while accepted as good");

  preamble_gate_a:
    assert property (!$past(check_preamble_en_in) |->
                     !stats_out.bad_preamble)
      else $error("preamble error reported while check disabled");

  sfd_gate_a:
    assert property (!$past(check_start_delimiter_in) |->
                     !stats_out.bad_start_delimiter)
      else $error("delimiter error reported while check disabled");

  fec_route_a:
    assert property ($rose(fec_path_en_in) |=> fec_route_out ##1
                     (fec_route_out == $past(fec_path_en_in)))
      else $error("FEC routing does not follow its enable");

  passthru_a:
    assert property (lane_data_valid_in |=>
                     egress_valid_out &&
                     egress_block_out == $past(lane_block_in))
      else $error("egress block altered or delayed");

  fault_cause_a:
    assert property ($changed(far_fault_flag_out) |->
                     $past(mon_valid))
      else $error("remote fault level moved without a block");

endmodule

//--- bench/tom_user_model.sv
// Partner model: user fabric logic feeding scrambled lane blocks.
// Assumes the bench fills q in whole cycles of five entries.
`timescale 1ns/1ps
module tom_user_model
  import tom_pkg::*;
(
  input wire logic clk_in,       // core clock
  input wire logic srst_in,      // synchronous reset
  input wire logic bubble_in,    // bubble request
  input wire logic skip_am_in,   // markers bypass scrambler
  output tom_lanes_t lanes_out,  // lane blocks
  output logic valid_out,        // blocks valid
  output logic lane0_out,        // lane 0 marker
  output logic am_out,           // marker cycle
  output logic end_out           // a frame starts or ends here
);
  // Entry: {marker, last, header, unscrambled payload}
  logic [67:0] q[$];
  logic [57:0] st = '0;
  int cyc = 0;
  int vcnt = 0;

  initial begin
    lanes_out = '0;
    valid_out = 1'b0;
    lane0_out = 1'b0;
    am_out = 1'b0;
    end_out = 1'b0;
  end

  always @(posedge clk_in) begin : drive
    logic r;
    logic b;
    logic [67:0] e;
    logic [63:0] p;
    r = srst_in;
    b = bubble_in;
    #2;
    valid_out = 1'b0;
    end_out = 1'b0;
    cyc = r ? 0 : (cyc + 1) % 66;
    if (r) begin
      st = '0;
      vcnt = 0;
    end
    // Gearbox needs two empty cycles in every 66
    if (!r && !b && cyc >= 2 && q.size() >= LANES) begin
      valid_out = 1'b1;
      lane0_out = (vcnt % 4 == 0);
      vcnt++;
      for (int i = 0; i < LANES; i++) begin
        e = q.pop_front();
        am_out = e[67];
        end_out = end_out | e[66];
        p = e[63:0];
        for (int k = 63; k >= 0; k--) begin
          if (!e[67])
            p[k] = e[k] ^ st[38] ^ st[57];
          // Raw markers feed the state unless they are skipped
          if (!(e[67] && skip_am_in))
            st = {st[56:0], p[k]};
        end
        lanes_out[i] = {e[65:64], p};
      end
    end else begin
      // Idle bus shows a changing pattern, the last word and its inverse in turn
      lanes_out = ~lanes_out;
      lane0_out = ~lane0_out;
      am_out = ~am_out;
    end
  end
endmodule

//--- bench/tom_monitor_test.sv
// Testbench for the client monitor: frame model with per-cycle checks.
// Assumes the partner model drives the lane side of the monitor.
`timescale 1ns/1ps
module tom_monitor_test;
  import tom_pkg::*;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  tom_lanes_t lanes, eg_blk;
  logic valid, lane0, am, ends, eg_v, eg_l0, eg_am, eg_bub, fec_r, ff;
  logic bubble = 1'b0;
  logic fec = 1'b0;
  // {stats, crc insert, accept bad, check preamble, check sfd}
  logic [4:0] cf = 5'h10;
  logic [14:0] maxl = 15'h0064;
  logic [7:0] minl = 8'h40;
  tom_stats_t st, p1;
  tom_stats_t exp_q[$];
  logic [31:0] seed = 32'h23E613DA;
  logic [7:0] tt [8] = '{8'h87, 8'h99, 8'hAA, 8'hB4, 8'hCC, 8'hD2,
                         8'hE1, 8'hFF};
  int lens [4] = '{101, 100, 64, 63};
  int fails = 0;
  int n_compared = 0;
  logic prst = 1'b1;

  tom_monitor u_tom_monitor (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .lane_block_in(lanes),
    .lane_data_valid_in(valid),
    .lane0_marker_in(lane0),
    .alignment_marker_flag_in(am),
    .bubble_request_in(bubble),
    .stats_config_in(cf[4]),
    .max_frame_length_in(maxl),
    .min_frame_length_in(minl),
    .check_start_delimiter_in(cf[0]),
    .check_preamble_en_in(cf[1]),
    .crc_insert_en_in(cf[3]),
    .accept_bad_crc_as_good_in(cf[2]),
    .fec_path_en_in(fec),
    .egress_block_out(eg_blk),
    .egress_valid_out(eg_v),
    .egress_lane0_out(eg_l0),
    .egress_am_out(eg_am),
    .egress_bubble_out(eg_bub),
    .fec_route_out(fec_r),
    .stats_out(st),
    .far_fault_flag_out(ff)
  );

  tom_user_model u_tom_user_model (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .bubble_in(bubble),
    .skip_am_in(cf[4]),
    .lanes_out(lanes),
    .valid_out(valid),
    .lane0_out(lane0),
    .am_out(am),
    .end_out(ends)
  );

  initial forever #50 clk_in = ~clk_in;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] crc32(logic [31:0] c, logic [7:0] b);
    for (int j = 0; j < 8; j++)
      c = (c[0] ^ b[j]) ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
    return c;
  endfunction

  task automatic chk(logic ok, string m);
    n_compared++;
    if (!ok) begin
      fails++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic put(logic [1:0] h, logic [63:0] w, logic a, logic l);
    logic [63:0] p;
    p = {<<{w}};
    u_tom_user_model.q.push_back({a, l, h, p});
  endtask

  task automatic cfg(logic [4:0] v, logic [14:0] mx, logic [7:0] mn);
    @(posedge clk_in);
    #2;
    cf = v;
    maxl = mx;
    minl = mn;
    #1;
  endtask

  task automatic drain();
    int t;
    t = 0;
    while (u_tom_user_model.q.size() > 0 && t < 500) begin
      @(posedge clk_in);
      t++;
    end
    if (t >= 500) begin
      fails++;
      $display("Error at %0t: lane queue stuck", $time);
      wrap_up();
    end else begin
      repeat (4) @(posedge clk_in);
      // Step off the edge so outputs read next are settled
      #1;
    end
  endtask

  // kind: 0 good FCS, 1 bad FCS, 2 inverted FCS
  task automatic frame(int len, int kind, logic bp, logic bs, logic a);
    logic [7:0] b[$];
    logic [31:0] c;
    logic [63:0] w;
    logic g, eg, lg, sh;
    tom_stats_t s;
    int s0, t0;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < len - 4; i++) begin
      b.push_back(8'(rnd()));
      c = crc32(c, b[i]);
    end
    c = (kind == 1) ? (~c ^ 32'h00000001) : ((kind == 2) ? c : ~c);
    for (int i = 0; i < 4; i++)
      b.push_back(c[8 * i +: 8]);
    w = 64'hD555555555555578;
    if (bp)
      w[15:8] = 8'h54;
    if (bs)
      w[63:56] = 8'hD4;
    // Start is flagged too: its checks report in its own cycle
    s0 = u_tom_user_model.q.size();
    put(SH_CTRL, w, 1'b0, 1'b1);
    while (b.size() >= 8) begin
      for (int k = 0; k < 8; k++)
        w[8 * k +: 8] = b.pop_front();
      put(SH_DATA, w, 1'b0, 1'b0);
      // Markers only fit on a whole cycle of lanes
      if (a && u_tom_user_model.q.size() % 5 == 0) begin
        repeat (5) put(SH_CTRL, 64'h0123456789ABCDEF, 1'b1, 1'b0);
        a = 1'b0;
      end
    end
    t0 = u_tom_user_model.q.size();
    w = 64'h0;
    w[7:0] = tt[b.size()];
    for (int k = 0; k < b.size(); k++)
      w[8 * k + 8 +: 8] = b[k];
    put(SH_CTRL, w, 1'b0, 1'b1);
    repeat (5) put(SH_CTRL, 64'h1E, 1'b0, 1'b0);
    while (u_tom_user_model.q.size() % 5 != 0)
      put(SH_CTRL, 64'h1E, 1'b0, 1'b0);
    g = (kind == 0);
    eg = g || (!cf[3] && cf[2]);
    lg = (len > maxl);
    sh = (len < minl);
    s = '0;
    s.bad_preamble = bp && cf[1];
    s.bad_start_delimiter = bs && cf[0];
    // Start and end in one lane cycle share one increment
    if (t0 / 5 != s0 / 5) begin
      exp_q.push_back(s);
      s = '0;
    end
    s.long_any_crc_count = lg;
    s.long_good_crc_count = lg && eg;
    s.long_bad_crc_count = lg && !eg;
    s.short_good_crc_count = {1'b0, sh && eg};
    s.short_bad_crc_count = {1'b0, sh && !eg};
    s.normal_bad_crc_count = len >= 64 && !lg && !g;
    s.inverted_crc_count = {2'b00, kind == 2};
    exp_q.push_back(s);
  endtask

  always @(posedge clk_in) begin
    #2;
    bubble = (rnd() % 8 == 0);
    fec = (rnd() % 2 == 1);
  end

  always @(posedge clk_in) begin : watch
    tom_stats_t e;
    #1;
    // Descramble stage then statistics register: one cycle late
    e = p1;
    p1 = '0;
    if (valid && ends && !srst_in && exp_q.size() > 0)
      p1 = exp_q.pop_front();
    if (srst_in) begin
      e = '0;
    end
    chk(st === e, "statistics increment");
    if (!prst) begin
      chk(eg_v === valid, "egress valid");
      chk(eg_l0 === (valid & lane0), "egress lane 0 mark");
      chk(eg_am === (valid & am), "egress marker flag");
      chk(eg_bub === bubble, "egress bubble");
      chk(fec_r === fec, "fec route");
      if (valid)
        chk(eg_blk === lanes, "egress blocks");
    end
    prst = srst_in;
  end

  initial begin
    repeat (10) @(posedge clk_in);
    #2;
    srst_in = 1'b0;
    for (int m = 0; m < 4; m++) begin
      cfg({1'b1, 2'(m), 2'b00}, 15'h0064, 8'h40);
      foreach (lens[i])
        for (int k = 0; k < 3; k++)
          frame(lens[i], k, 1'b0, 1'b0, 1'b0);
      drain();
    end
    $display("length and FCS bins test done");
    for (int m = 0; m < 4; m++) begin
      cfg({3'b110, 2'(m)}, 15'h0064, 8'h40);
      frame(80, 0, 1'b1, 1'b0, 1'b0);
      frame(80, 0, 1'b0, 1'b1, 1'b0);
      drain();
    end
    $display("preamble and delimiter test done");
    frame(120, 1, 1'b0, 1'b0, 1'b1);
    drain();
    cfg(5'h00, 15'h0064, 8'h40);
    repeat (5) put(SH_CTRL, 64'h0123456789ABCDEF, 1'b1, 1'b0);
    frame(90, 2, 1'b0, 1'b0, 1'b0);
    drain();
    $display("alignment marker test done");
    cfg(5'h10 | 5'(rnd() % 16), 15'h0040 + 15'(rnd() % 200), 8'(rnd()));
    repeat (30)
      frame(20 + rnd() % 240, rnd() % 3, 1'(rnd()), 1'(rnd()), 1'b0);
    drain();
    $display("random frame test done");
    chk(ff === 1'b0, "remote fault idle");
    put(SH_CTRL, 64'h000000000200004B, 1'b0, 1'b0);
    repeat (4) put(SH_DATA, 64'h0, 1'b0, 1'b0);
    drain();
    repeat (3) begin
      @(posedge clk_in);
      #1;
      chk(ff === 1'b1, "remote fault level");
    end
    repeat (5) put(SH_CTRL, 64'h1E, 1'b0, 1'b0);
    drain();
    chk(ff === 1'b0, "remote fault cleared");
    $display("remote fault test done");
    chk(exp_q.size() == 0, "frames never reported");
    wrap_up();
  end
endmodule
